// ===== hw/esr_pkg.sv
// How it works
// - suspend accepted only while erase busy, unsuspended
// - suspend ignored during whole-chip erase
// - status writes rejected while suspended
// - all erases rejected while suspended
// - other-region read/program allowed while suspended
// - suspend sets flag, busy drops within latency
// - power loss clears suspended state and flag
// - resume accepted only when suspended and idle
// - resume clears flag, busy within 200ns
// - resume ignored after power-lost suspend
// - security erase needs write enable latch
// - address 00h, bits15-12 register, bits11-8 zero
// - erase starts only on exact final rise
// - erase self-timed, then busy and latch clear
// - locked register ignores erase
// - program needs latch, 1-256 bytes, select low
// - locked register ignores program
// - read is opcode, address, eight dummy clocks
// - sample rising, drive falling, msb first
// - read offset increments, wraps within register
// - read ignored while busy
// - security erase only in single-line mode
package esr_pkg;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_CE1 = 8'hc7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] SEC_UPPER = 8'h00;
  localparam logic [3:0] SEC_MID = 4'h0;
  localparam int SEC_REGS = 4;
  localparam int SEC_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int CLK_MHZ = 20;
  localparam int RESUME_BUSY_NS = 200;
  // longest time rounds down
  localparam int RESUME_BUSY_CYC = (RESUME_BUSY_NS * CLK_MHZ) / 1000;
  localparam int SUSPEND_LATENCY_US = 20;
  localparam int SUSPEND_LATENCY_CYC = SUSPEND_LATENCY_US * CLK_MHZ;
  localparam int SECTOR_ERASE_TIME_MS = 60;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_MS * CLK_MHZ * 1000;
  localparam int CMD_BITS = 8;
  localparam int ADDR_END_BITS = 32;
  localparam int DUMMY_END_BITS = 40;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  typedef enum logic [3:0] {
    ESR_IDLE = 4'b0001,
    ESR_ERASE = 4'b0010,
    ESR_SUSP = 4'b0100,
    ESR_RESUME = 4'b1000
  } esr_state_t;
endpackage

// ===== hw/esr_core.sv
`timescale 1ns/10ps
`default_nettype none
module esr_core #(
  parameter int EraseCycles = esr_pkg::SECTOR_ERASE_CYC,
  parameter int SuspendCycles = esr_pkg::SUSPEND_LATENCY_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic serialInLine,
  input wire logic quadMode,
  input wire logic [3:0] otpLockBits,
  input wire logic writeEnableLatchIn,
  input wire logic arrayEraseBusy,
  input wire logic arrayEraseIsChip,
  output logic serialOutLine,
  output logic serialOutEnable,
  output logic busy,
  output logic eraseSuspendedFlag,
  output logic writeEnableLatchClear,
  output logic suspendRequest,
  output logic resumeRequest,
  output logic statusWriteReject,
  output logic eraseReject
);
  import esr_pkg::*;

  // ----------------------------------------
  // link domain: command shifter
  // ----------------------------------------
  logic [7:0] secMem [SEC_REGS][SEC_BYTES];
  logic [5:0] bitCnt;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] shiftIn;
  logic [7:0] offset;
  logic [7:0] readByte;
  logic [2:0] outBit;
  logic reading;
  logic suspReqTgl;
  logic resReqTgl;
  logic swrTgl;
  logic erjTgl;
  logic [1:0] eraseReg;
  logic [1:0] busyL;
  logic [1:0] suspL;
  logic [1:0] welL;
  logic [3:0] eraseDoneL;
  logic [1:0] eraseDoneS;
  logic eraseDoneSeen;
  wire logic [7:0] nextOp = {opcode[6:0], serialInLine};
  wire logic [7:0] nextByte = {shiftIn[6:0], serialInLine};
  wire logic addrOk = addr[23:16] == SEC_UPPER && addr[15:14] == 2'b00 && addr[11:8] == SEC_MID;
  wire logic [1:0] regSel = addr[13:12];

  always_ff @(posedge spiClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busyL <= 2'b00;
      suspL <= 2'b00;
      welL <= 2'b00;
    end
    else
    begin
      busyL <= {busyL[0], busy};
      suspL <= {suspL[0], eraseSuspendedFlag};
      welL <= {welL[0], writeEnableLatchIn};
    end
  end

  // rising edge sampling; select high holds reset of frame state
  always_ff @(posedge spiClk or posedge chipSelectN)
  begin
    if (chipSelectN)
    begin
      bitCnt <= 6'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
      shiftIn <= 8'h00;
      reading <= 1'b0;
    end
    else
    begin
      // long streams fold back so the low bits keep counting bytes
      if (bitCnt == 6'h3f)
        bitCnt <= 6'h38;
      else
        bitCnt <= bitCnt + 6'h01;
      if (bitCnt < 6'(CMD_BITS))
        opcode <= nextOp;
      else if (bitCnt < 6'(ADDR_END_BITS))
        addr <= {addr[22:0], serialInLine};
      shiftIn <= nextByte;
      // read only when idle; address then eight dummy clocks
      if (opcode == OP_SEC_READ && bitCnt == 6'(DUMMY_END_BITS - 1) && !busyL[1] && addrOk)
        reading <= 1'b1;
    end
  end

  // frame decode on link clock; edges toggled over to clk
  always_ff @(posedge spiClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      suspReqTgl <= 1'b0;
      resReqTgl <= 1'b0;
      swrTgl <= 1'b0;
      erjTgl <= 1'b0;
    end
    else if (!chipSelectN && bitCnt == 6'(CMD_BITS - 1))
    begin
      if (nextOp == OP_SUSPEND && busyL[1] && !suspL[1])
        suspReqTgl <= ~suspReqTgl;
      if (nextOp == OP_RESUME && suspL[1] && !busyL[1])
        resReqTgl <= ~resReqTgl;
      if (suspL[1] && (nextOp == OP_WRSR1 || nextOp == OP_WRSR2 || nextOp == OP_WRSR3))
        swrTgl <= ~swrTgl;
      if (suspL[1] && (nextOp == OP_SE || nextOp == OP_BE32 || nextOp == OP_BE64 || nextOp == OP_CE1
          || nextOp == OP_CE2 || nextOp == OP_SEC_ERASE))
        erjTgl <= ~erjTgl;
    end
  end

  // program write and erase fill share one write port on link clock
  always_ff @(posedge spiClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      offset <= 8'h00;
      eraseDoneL <= 4'h0;
    end
    else
    begin
      eraseDoneL <= {eraseDoneL[2:0], eraseDoneS[1]};
      // whole register filled at once after the timed erase
      if (eraseDoneL[3] != eraseDoneL[2])
      begin
        for (int i = 0; i < SEC_BYTES; i++)
          secMem[eraseReg][i] <= ERASED_BYTE;
      end
      else if (!chipSelectN)
      begin
        if (bitCnt == 6'(ADDR_END_BITS - 1))
          offset <= nextByte;
        // program: latch, lock, not busy, wrap in register
        if (opcode == OP_SEC_PROG && bitCnt >= 6'(ADDR_END_BITS) && bitCnt[2:0] == 3'd7 && welL[1]
            && !busyL[1] && addrOk && !otpLockBits[regSel])
        begin
          secMem[regSel][offset] <= secMem[regSel][offset] & nextByte;
          offset <= offset + 8'h01;
        end
        if (reading && bitCnt[2:0] == 3'd7)
          offset <= offset + 8'h01;
      end
    end
  end

  // erase starts only when select rises right after address
  always_ff @(posedge chipSelectN or negedge arst_n)
  begin
    if (!arst_n)
    begin
      eraseDoneSeen <= 1'b0;
      eraseReg <= 2'b00;
    end
    else if (opcode == OP_SEC_ERASE && bitCnt == 6'(ADDR_END_BITS) && welL[1] && !busyL[1] && !suspL[1]
             && !quadMode && addrOk && !otpLockBits[regSel])
    begin
      eraseDoneSeen <= ~eraseDoneSeen;
      eraseReg <= regSel;
    end
  end

  // falling edge drive, msb first
  always_ff @(negedge spiClk or posedge chipSelectN)
  begin
    if (chipSelectN)
    begin
      outBit <= 3'd7;
      readByte <= 8'h00;
      serialOutLine <= 1'b0;
      serialOutEnable <= 1'b0;
    end
    else if (reading)
    begin
      serialOutEnable <= 1'b1;
      if (outBit == 3'd7)
      begin
        readByte <= secMem[regSel][offset];
        serialOutLine <= secMem[regSel][offset][7];
      end
      else
        serialOutLine <= readByte[outBit];
      outBit <= outBit - 3'd1;
    end
  end

  // ----------------------------------------
  // core domain: suspend/resume and timers
  // ----------------------------------------
  logic [2:0] suspS;
  logic [2:0] resS;
  logic [2:0] swrS;
  logic [2:0] erjS;
  logic [2:0] ersS;
  esr_state_t state;
  logic [CNT_W-1:0] timer;
  logic secErase;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      suspS <= 3'b000;
      resS <= 3'b000;
      swrS <= 3'b000;
      erjS <= 3'b000;
      ersS <= 3'b000;
    end
    else
    begin
      suspS <= {suspS[1:0], suspReqTgl};
      resS <= {resS[1:0], resReqTgl};
      swrS <= {swrS[1:0], swrTgl};
      erjS <= {erjS[1:0], erjTgl};
      ersS <= {ersS[1:0], eraseDoneSeen};
    end
  end

  // power loss is arst_n: all suspend state cleared
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ESR_IDLE;
      timer <= CNT_ZERO;
      busy <= 1'b0;
      eraseSuspendedFlag <= 1'b0;
      secErase <= 1'b0;
      writeEnableLatchClear <= 1'b0;
      suspendRequest <= 1'b0;
      resumeRequest <= 1'b0;
      eraseDoneS <= 2'b00;
    end
    else
    begin
      writeEnableLatchClear <= 1'b0;
      suspendRequest <= 1'b0;
      resumeRequest <= 1'b0;
      case (state)
        ESR_IDLE:
        begin
          busy <= arrayEraseBusy;
          if (ersS[2] != ersS[1])
          begin
            state <= ESR_ERASE;
            secErase <= 1'b1;
            busy <= 1'b1;
            timer <= CNT_W'(EraseCycles);
          end
          else if (suspS[2] != suspS[1] && arrayEraseBusy && !arrayEraseIsChip)
          begin
            state <= ESR_SUSP;
            eraseSuspendedFlag <= 1'b1;
            suspendRequest <= 1'b1;
            timer <= CNT_W'(SuspendCycles);
          end
        end
        ESR_ERASE:
        begin
          // self-timed erase, then busy and latch clear
          if (timer == CNT_ZERO)
          begin
            state <= ESR_IDLE;
            busy <= 1'b0;
            secErase <= 1'b0;
            writeEnableLatchClear <= 1'b1;
            eraseDoneS[1] <= ~eraseDoneS[1];
          end
          else
            timer <= timer - CNT_W'(1);
        end
        ESR_SUSP:
        begin
          if (timer != CNT_ZERO)
            timer <= timer - CNT_W'(1);
          else
            busy <= 1'b0;
          if (resS[2] != resS[1] && !busy)
          begin
            state <= ESR_RESUME;
            eraseSuspendedFlag <= 1'b0;
            resumeRequest <= 1'b1;
            timer <= CNT_W'(RESUME_BUSY_CYC - 1);
          end
        end
        ESR_RESUME:
        begin
          busy <= 1'b1;
          if (timer == CNT_ZERO)
          begin
            state <= ESR_IDLE;
            busy <= 1'b1;
          end
          else
            timer <= timer - CNT_W'(1);
        end
        default:
          state <= ESR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      statusWriteReject <= 1'b0;
      eraseReject <= 1'b0;
    end
    else
    begin
      statusWriteReject <= swrS[2] != swrS[1];
      eraseReject <= erjS[2] != erjS[1];
    end
  end
endmodule
`default_nettype wire

// ===== verification/esr_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module esr_core_assertions #(
  parameter int SuspendCycles = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic arrayEraseBusy,
  input wire logic arrayEraseIsChip,
  input wire logic busy,
  input wire logic eraseSuspendedFlag,
  input wire logic writeEnableLatchClear,
  input wire logic suspendRequest,
  input wire logic resumeRequest,
  input wire logic statusWriteReject,
  input wire logic eraseReject,
  input wire logic serialOutEnable
);
  localparam int SuspMax = SuspendCycles + 12;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence flagGone;
    ##[0:3] !eraseSuspendedFlag;
  endsequence
  sequence busyBack;
    ##[0:4] busy;
  endsequence
  sus_flag_a: assert property (suspendRequest |-> ##[0:3] eraseSuspendedFlag)
    else $error("suspend flag missing");
  sus_drop_a: assert property ($rose(eraseSuspendedFlag) |-> ##[0:SuspMax] !busy)
    else $error("busy stayed after suspend");
  sus_cause_a: assert property (suspendRequest |-> arrayEraseBusy && !arrayEraseIsChip)
    else $error("suspend without sector erase");
  res_cause_a: assert property (resumeRequest |-> $past(eraseSuspendedFlag) && !$past(busy))
    else $error("resume without suspend");
  res_busy_a: assert property (resumeRequest |-> flagGone ##0 busyBack)
    else $error("resume flag or busy wrong");
  rej_susp_a: assert property (eraseReject || statusWriteReject |-> eraseSuspendedFlag)
    else $error("reject outside suspend");
  rej_pulse_a: assert property (eraseReject |=> !eraseReject)
    else $error("reject pulse too long");
  wel_end_a: assert property (writeEnableLatchClear |-> ##[0:2] !busy)
    else $error("latch clear while busy");
  rd_idle_a: assert property (serialOutEnable |-> !busy)
    else $error("read data while busy");
endmodule
bind esr_core esr_core_assertions #(.SuspendCycles(SuspendCycles)) u_chk (.clk(clk), .arst_n(arst_n),
  .arrayEraseBusy(arrayEraseBusy), .arrayEraseIsChip(arrayEraseIsChip), .busy(busy),
  .eraseSuspendedFlag(eraseSuspendedFlag), .writeEnableLatchClear(writeEnableLatchClear),
  .suspendRequest(suspendRequest), .resumeRequest(resumeRequest), .statusWriteReject(statusWriteReject),
  .eraseReject(eraseReject), .serialOutEnable(serialOutEnable));
`default_nettype wire

// ===== verification/esr_host.sv
`timescale 1ns/10ps
`default_nettype none
module esr_host (
  output var logic spiClk,
  output var logic chipSelectN,
  output var logic serialInLine,
  input wire logic serialOutLine,
  input wire logic serialOutEnable
);
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic sawOut = 1'b0;
  initial
  begin
    spiClk = 1'b0;
    chipSelectN = 1'b1;
    serialInLine = 1'b0;
  end
  // link clock rests low between frames
  task automatic tick(input logic b);
    serialInLine = b;
    #16 spiClk = 1'b1;
    #16 spiClk = 1'b0;
  endtask
  task automatic frame(input logic [39:0] hdr, input int nb, input int nrd);
    logic [7:0] v;
    chipSelectN = 1'b0;
    #16;
    for (int i = 0; i < nb; i++) tick(hdr[39-i]);
    while (wq.size() > 0)
    begin
      v = wq.pop_front();
      for (int i = 7; i >= 0; i--) tick(v[i]);
    end
    repeat (nrd)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        #16 spiClk = 1'b1;
        v[i] = serialOutLine;
        sawOut |= serialOutEnable;
        #16 spiClk = 1'b0;
      end
      rq.push_back(v);
    end
    #16 chipSelectN = 1'b1;
    serialInLine = ~serialInLine;
    #16;
  endtask
endmodule
`default_nettype wire

// ===== verification/erase_suspend_security_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module erase_suspend_security_regs_tb_top;
  import esr_pkg::*;
  logic clk, arst_n, quadMode, writeEnableLatchIn, arrayEraseBusy, arrayEraseIsChip, serialOutEnable;
  logic spiClk, chipSelectN, serialInLine, serialOutLine, busy, eraseSuspendedFlag, writeEnableLatchClear;
  logic suspendRequest, resumeRequest, statusWriteReject, eraseReject;
  logic [3:0] otpLockBits;
  logic [7:0] opList[9] = '{OP_WRSR1, OP_WRSR2, OP_WRSR3, OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2, OP_SEC_ERASE};
  int err_total = 0, compares = 0, seed = 11664, cyc = 0;
  int nSus = 0, nRes = 0, nRej = 0, nSwr = 0, nWel = 0, expWel = 0;
  int mem[4][256];
  esr_core #(.EraseCycles(60), .SuspendCycles(4)) i_dut (.clk(clk), .arst_n(arst_n), .spiClk(spiClk),
    .chipSelectN(chipSelectN), .serialInLine(serialInLine), .quadMode(quadMode), .otpLockBits(otpLockBits),
    .writeEnableLatchIn(writeEnableLatchIn), .arrayEraseBusy(arrayEraseBusy), .arrayEraseIsChip(arrayEraseIsChip),
    .serialOutLine(serialOutLine), .serialOutEnable(serialOutEnable), .busy(busy),
    .eraseSuspendedFlag(eraseSuspendedFlag), .writeEnableLatchClear(writeEnableLatchClear),
    .suspendRequest(suspendRequest), .resumeRequest(resumeRequest), .statusWriteReject(statusWriteReject),
    .eraseReject(eraseReject));
  esr_host i_host (.spiClk(spiClk), .chipSelectN(chipSelectN), .serialInLine(serialInLine),
    .serialOutLine(serialOutLine), .serialOutEnable(serialOutEnable));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pulse counters and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    nSus <= nSus + int'(suspendRequest === 1'b1);
    nRes <= nRes + int'(resumeRequest === 1'b1);
    nRej <= nRej + int'(eraseReject === 1'b1);
    nSwr <= nSwr + int'(statusWriteReject === 1'b1);
    nWel <= nWel + int'(writeEnableLatchClear === 1'b1);
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      summarize();
    end
  end
  task automatic waitCk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c);
    i_host.frame({c, 32'h0}, 8, 0);
    waitCk(6);
  endtask
  task automatic secErase(input int r, input int nb);
    logic ok;
    ok = writeEnableLatchIn && !quadMode && !otpLockBits[r] && nb == 32;
    i_host.sawOut = 1'b0;
    i_host.frame({OP_SEC_ERASE, 8'h00, 4'(r), 12'h000, 8'h00}, nb, 0);
    i_host.frame({OP_SEC_READ, 32'h0}, 40, 1);
    chkVal(i_host.sawOut, !ok);
    i_host.rq.delete();
    waitCk(50);
    i_host.frame(40'h0, 8, 0);
    waitCk(4);
    if (ok) expWel++;
    if (ok) mem[r] = '{default: 255};
    chkVal(nWel, expWel);
  endtask
  task automatic secProg(input int r, input int off, input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($random(seed));
      i_host.wq.push_back(b);
      if (writeEnableLatchIn && !otpLockBits[r]) mem[r][(off + i) % 256] &= b;
    end
    i_host.frame({OP_SEC_PROG, 8'h00, 4'(r), 4'h0, 8'(off), 8'h00}, 32, 0);
    waitCk(40);
  endtask
  task automatic secRead(input int r, input int off, input int n);
    i_host.frame({OP_SEC_READ, 8'h00, 4'(r), 4'h0, 8'(off), 8'h00}, 40, n);
    for (int i = 0; i < n; i++) chkVal(i_host.rq.pop_front(), mem[r][(off + i) % 256]);
    waitCk(2);
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    arst_n = 1'b0;
    quadMode = 1'b0;
    writeEnableLatchIn = 1'b1;
    arrayEraseBusy = 1'b0;
    arrayEraseIsChip = 1'b0;
    otpLockBits = 4'h0;
    i_host.frame(40'h0, 8, 0);
    waitCk(4);
    arst_n = 1'b1;
    chkVal({busy, eraseSuspendedFlag, serialOutEnable}, 0);
    waitCk(3);
    for (int r = 0; r < 4; r++) secErase(r, 32);
    secProg(1, 8'hf0, 24);
    secRead(1, 8'hf8, 264);
    otpLockBits = 4'h2;
    secProg(1, 0, 4);
    secErase(1, 32);
    secRead(1, 8'hf0, 20);
    otpLockBits = 4'h0;
    secProg(0, 0, 4);
    writeEnableLatchIn = 1'b0;
    secErase(0, 32);
    secProg(0, 4, 2);
    writeEnableLatchIn = 1'b1;
    quadMode = 1'b1;
    secErase(0, 32);
    quadMode = 1'b0;
    secErase(0, 33);
    secRead(0, 0, 8);
    arrayEraseBusy = 1'b1;
    arrayEraseIsChip = 1'b1;
    op(OP_SUSPEND);
    chkVal(nSus, 0);
    arrayEraseIsChip = 1'b0;
    op(OP_SUSPEND);
    arrayEraseBusy = 1'b0;
    chkVal(nSus * 2 + eraseSuspendedFlag, 3);
    op(OP_SUSPEND);
    foreach (opList[i]) op(opList[i]);
    chkVal(nSus * 100 + nRej * 10 + nSwr, 163);
    secRead(2, 8'h40, 4);
    op(OP_RESUME);
    chkVal(nRes * 2 + eraseSuspendedFlag, 2);
    arrayEraseBusy = 1'b1;
    waitCk(4);
    op(OP_RESUME);
    op(OP_SUSPEND);
    chkVal(nRes * 10 + nSus, 12);
    arst_n = 1'b0;
    i_host.frame(40'h0, 8, 0);
    waitCk(4);
    arst_n = 1'b1;
    arrayEraseBusy = 1'b0;
    chkVal(eraseSuspendedFlag, 0);
    waitCk(3);
    op(OP_RESUME);
    chkVal(nRes, 1);
    summarize();
  end
endmodule
`default_nettype wire
